// ---- indir_consts.vh ----
`ifndef INDIR_CONSTS_VH
`define INDIR_CONSTS_VH
// Indirection region bounds, inclusive.
`define INDIR_REGION_LO 16'hCCE5
`define INDIR_REGION_HI 16'hD4E7
// Table base addresses chosen inside the region.
`define RO_ADDR_BASE 16'hCCE5
`define RO_VAL_BASE 16'hCEE5
`define RW_ADDR_BASE 16'hD0E5
`define RW_VAL_BASE 16'hD2E5
`define TABLE_SPAN 16'h0200
`define ENTRY_RESET 16'h0000
`endif

// ---- indir_table.v ----
`timescale 1ns/100ps
`include "indir_consts.vh"
// One table's address half, with one entry set for each host.
module indir_table #(
    parameter HOSTS = 4,
    parameter HOST_W = 2,
    parameter ENTRIES = 64,
    parameter IDX_W = 6
)(
    input wire clk,
    input wire reset_n,
    input wire wr_en,
    input wire [HOST_W-1:0] wr_host,
    input wire [IDX_W-1:0] wr_idx,
    input wire [15:0] wr_data,
    input wire clr_en,
    input wire [HOST_W-1:0] clr_host,
    input wire [HOST_W-1:0] rd_host,
    input wire [IDX_W-1:0] rd_idx,
    output wire [15:0] rd_data
);
    reg [15:0] entry [0:HOSTS*ENTRIES-1];
    wire in_region;
    assign in_region = (wr_data >= `INDIR_REGION_LO) && (wr_data <= `INDIR_REGION_HI);
    assign rd_data = entry[{rd_host, rd_idx}];
    genvar g;
    generate
        for (g = 0; g < HOSTS*ENTRIES; g = g + 1)
        begin : gen_entry
            always @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    entry[g] <= `ENTRY_RESET;
                else if (clr_en && clr_host == g / ENTRIES)
                    entry[g] <= `ENTRY_RESET;
                else if (wr_en && !in_region && {wr_host, wr_idx} == g)
                    entry[g] <= wr_data;
            end
        end
    endgenerate
endmodule

// ---- modbus_indirection_tables.v ----
`timescale 1ns/100ps
`include "indir_consts.vh"
// Functional notes
// - One read-only and one read/write table
// - Lower half addresses, upper half values
// - Block request served one register per request
// - Ethernet disconnect or power loss clears
// - Multi-register write loads consecutive address slots
// - Private table set per host
// - Region addresses refused as table entries
module modbus_indirection_tables #(
    parameter HOSTS = 4,
    parameter HOST_W = 2,
    parameter ENTRIES = 64,
    parameter IDX_W = 6
)(
    input wire clk,
    input wire reset_n,
    input wire req_valid,
    input wire req_write,
    input wire [HOST_W-1:0] req_host,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    input wire host_drop,
    input wire [HOST_W-1:0] drop_host,
    input wire power_fail,
    output reg req_done,
    output reg req_hit,
    output reg [15:0] req_rdata,
    output reg tgt_valid,
    output reg tgt_write,
    output reg [15:0] tgt_addr,
    output reg [15:0] tgt_wdata,
    input wire tgt_ready,
    input wire [15:0] tgt_rdata
);
    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_DONE = 2'b10;
    reg [1:0] state;
    reg [15:0] off;
    reg [1:0] sel;
    reg [IDX_W-1:0] idx;
    reg clr_all;
    reg [HOST_W-1:0] clr_cnt;
    reg [15:0] ro_map;
    reg [15:0] rw_map;
    wire [15:0] ro_q;
    wire [15:0] rw_q;
    // Decode which quarter of the region the request falls in.
    always @*
    begin
        sel = 2'b00;
        off = 16'h0000;
        if (req_addr >= `RO_ADDR_BASE && req_addr < `RO_VAL_BASE)
        begin
            sel = 2'b00;
            off = req_addr - `RO_ADDR_BASE;
        end
        else if (req_addr >= `RO_VAL_BASE && req_addr < `RW_ADDR_BASE)
        begin
            sel = 2'b01;
            off = req_addr - `RO_VAL_BASE;
        end
        else if (req_addr >= `RW_ADDR_BASE && req_addr < `RW_VAL_BASE)
        begin
            sel = 2'b10;
            off = req_addr - `RW_ADDR_BASE;
        end
        else
        begin
            sel = 2'b11;
            off = req_addr - `RW_VAL_BASE;
        end
        idx = off[IDX_W-1:0];
    end
    // Slots beyond ENTRIES answer as misses rather than aliasing onto low slots.
    wire in_table;
    assign in_table = (req_addr >= `RO_ADDR_BASE) && (req_addr < `RW_VAL_BASE + `TABLE_SPAN)
        && (off < ENTRIES);
    // Power loss wipes every host's set, one host per cycle.
    wire clr_en;
    wire [HOST_W-1:0] clr_host;
    assign clr_en = host_drop || clr_all;
    assign clr_host = clr_all ? clr_cnt : drop_host;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clr_all <= 1'b0;
            clr_cnt <= {HOST_W{1'b0}};
        end
        else if (power_fail)
        begin
            clr_all <= 1'b1;
            clr_cnt <= {HOST_W{1'b0}};
        end
        // A drop request pauses the power sweep for a cycle, so that no host is skipped.
        else if (clr_all && !host_drop)
        begin
            clr_cnt <= clr_cnt + 1'b1;
            if (clr_cnt == HOSTS - 1)
                clr_all <= 1'b0;
        end
    end
    // A power clear blocks new requests, so no host reads a half-cleared set.
    wire busy;
    assign busy = clr_all || state != ST_IDLE;
    wire take;
    assign take = req_valid && !busy;
    // Each consecutive register of a multi-register write arrives as its own request.
    wire wr_ro = take && in_table && req_write && sel == 2'b00;
    wire wr_rw = take && in_table && req_write && sel == 2'b10;
    // Both tables share one index and host select, so both keep the same slot order.
    indir_table #(
        .HOSTS(HOSTS),
        .HOST_W(HOST_W),
        .ENTRIES(ENTRIES),
        .IDX_W(IDX_W)
    ) u_ro (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_ro),
        .wr_host(req_host),
        .wr_idx(idx),
        .wr_data(req_wdata),
        .clr_en(clr_en),
        .clr_host(clr_host),
        .rd_host(req_host),
        .rd_idx(idx),
        .rd_data(ro_q)
    );
    indir_table #(
        .HOSTS(HOSTS),
        .HOST_W(HOST_W),
        .ENTRIES(ENTRIES),
        .IDX_W(IDX_W)
    ) u_rw (
        .clk(clk),
        .reset_n(reset_n),
        .wr_en(wr_rw),
        .wr_host(req_host),
        .wr_idx(idx),
        .wr_data(req_wdata),
        .clr_en(clr_en),
        .clr_host(clr_host),
        .rd_host(req_host),
        .rd_idx(idx),
        .rd_data(rw_q)
    );
    always @*
    begin
        ro_map = ro_q;
        rw_map = rw_q;
    end
    // One request per register; the host's block request is thus served word by word.
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_IDLE;
            req_done <= 1'b0;
            req_hit <= 1'b0;
            req_rdata <= 16'h0000;
            tgt_valid <= 1'b0;
            tgt_write <= 1'b0;
            tgt_addr <= 16'h0000;
            tgt_wdata <= 16'h0000;
        end
        else
        begin
            req_done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        req_hit <= in_table;
                        req_rdata <= 16'h0000;
                        if (!in_table)
                            state <= ST_DONE;
                        else if (sel == 2'b00 || sel == 2'b10)
                        begin
                            req_rdata <= req_write ? 16'h0000 : (sel == 2'b00 ? ro_map : rw_map);
                            state <= ST_DONE;
                        end
                        else if (sel == 2'b01 && req_write)
                            state <= ST_DONE;
                        else
                        begin
                            tgt_valid <= 1'b1;
                            tgt_write <= req_write;
                            tgt_addr <= (sel == 2'b01) ? ro_map : rw_map;
                            tgt_wdata <= req_wdata;
                            state <= ST_WAIT;
                        end
                    end
                end
                // There is no timeout on the target, so a target that never answers hangs the port.
                ST_WAIT:
                begin
                    if (tgt_ready)
                    begin
                        tgt_valid <= 1'b0;
                        req_rdata <= tgt_write ? 16'h0000 : tgt_rdata;
                        state <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    req_done <= 1'b1;
                    state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule

// ---- modbus_indirection_tables_props.sv ----
`timescale 1ns/100ps
`include "indir_consts.vh"
module modbus_indirection_tables_props #(parameter ENTRIES = 64)(
    input wire clk,
    input wire reset_n,
    input wire req_valid,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire req_done,
    input wire req_hit,
    input wire [15:0] req_rdata,
    input wire tgt_valid,
    input wire tgt_write,
    input wire [15:0] tgt_addr,
    input wire [15:0] tgt_wdata,
    input wire tgt_ready,
    input wire [15:0] tgt_rdata
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
logic busy;
wire take = req_valid && (!busy || req_done);
wire [15:0] a = req_addr;
wire ro_adr = a >= `RO_ADDR_BASE && a < `RO_ADDR_BASE + ENTRIES;
wire rw_adr = a >= `RW_ADDR_BASE && a < `RW_ADDR_BASE + ENTRIES;
wire ro_val = a >= `RO_VAL_BASE && a < `RO_VAL_BASE + ENTRIES;
wire rw_val = a >= `RW_VAL_BASE && a < `RW_VAL_BASE + ENTRIES;
// Tracks one request in flight, so take mirrors the design's acceptance edge.
always @(posedge clk or negedge reset_n)
    if (!reset_n)
        busy <= 1'b0;
    else
        busy <= take ? 1'b1 : (req_done ? 1'b0 : busy);
chk_done_pulse: assert property (req_done |=> !req_done)
    else $error("done held too long");
chk_tgt_hold: assert property (tgt_valid && !tgt_ready |=> tgt_valid
    && $stable({tgt_write, tgt_addr, tgt_wdata})) else $error("target request moved");
chk_tgt_drop: assert property (tgt_valid && tgt_ready |=> !tgt_valid)
    else $error("target request not released");
chk_rdata_catch: assert property (tgt_valid && tgt_ready && !tgt_write |-> ##2
    req_done && req_rdata == $past(tgt_rdata, 2)) else $error("read value lost");
chk_ro_guard: assert property (take && req_write && ro_val |=> !tgt_valid ##1
    (!tgt_valid && req_done)) else $error("read-only value write reached target");
chk_addr_done: assert property (take && (ro_adr || rw_adr) |=> !tgt_valid ##1
    (req_done && req_hit)) else $error("address half access wrong");
chk_miss_zero: assert property (take && !(ro_adr || rw_adr || ro_val || rw_val) |-> ##2
    (req_done && !req_hit && req_rdata == 16'h0000)) else $error("miss answered wrongly");
chk_val_launch: assert property (take && (rw_val || ro_val && !req_write) |=>
    tgt_valid && tgt_write == $past(req_write)) else $error("value access not launched");
chk_idle_quiet: assert property (!busy |-> !tgt_valid)
    else $error("target access without request");
endmodule

// ---- modbus_indirection_tables_tb_top.sv ----
`timescale 1ns/100ps
module modbus_indirection_tables_tb_top;
logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, host_drop = 0, power_fail = 0, hit;
logic [1:0] req_host = 0, drop_host = 0, lag = 0;
logic [15:0] req_addr = 0, req_wdata = 0, rd, d, tbl [4][4];
logic req_done, req_hit, tgt_valid, tgt_write, tgt_ready;
logic [15:0] req_rdata, tgt_addr, tgt_wdata, tgt_rdata;
logic [15:0] shadow [int];
int n_errors = 0, n_tests = 0, seed = 32'hf5accf11;
always #5 clk = ~clk;
modbus_indirection_tables #(.ENTRIES(4), .IDX_W(2)) modbus_indirection_tables_inst (.*);
tgt_model tgt_model_inst (.*);
function automatic [15:0] tval(input [15:0] a);
    return shadow.exists(a) ? shadow[a] : ~a;
endfunction
task check(input [31:0] got, input [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
        n_errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task xfer(input [1:0] h, input w, input [15:0] a, input [15:0] v);
    int n;
    @(posedge clk);
    #1 {req_host, req_write, req_addr, req_wdata, req_valid} = {h, w, a, v, 1'b1};
    lag = 2'($random(seed));
    n = 0;
    do begin @(posedge clk); #1 n++; end while (req_done !== 1'b1 && n < 60);
    if (n >= 60)
        n_errors++;
    {rd, hit, req_valid} = {req_rdata, req_hit, 1'b0};
endtask
task conclude;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
initial begin
    repeat (6) @(posedge clk);
    #1 reset_n = 1;
    xfer(0, 0, 16'h1234, 0);
    check({hit, rd}, 0);
    xfer(0, 0, 16'hD0E9, 0);
    check(hit, 0);
    for (int h = 0; h < 4; h++)
        for (int i = 0; i < 4; i++)
        begin
            tbl[h][i] = 16'($random(seed)) & 16'h7FFF;
            xfer(h, 1, 16'hD0E5 + i, tbl[h][i]);
            xfer(h, 1, 16'hCCE5 + i, tbl[h][i]);
            d = 16'($random(seed));
            xfer(h, 1, 16'hD2E5 + i, d);
            shadow[tbl[h][i]] = d;
        end
    for (int h = 0; h < 4; h++)
        for (int i = 0; i < 4; i++)
        begin
            xfer(h, 0, 16'hD0E5 + i, 0);
            check(rd, tbl[h][i]);
            xfer(h, 0, 16'hCEE5 + i, 0);
            check(rd, tval(tbl[h][i]));
        end
    $display("table load test done");
    xfer(0, 1, 16'hCEE5, ~tval(tbl[0][0]));
    xfer(0, 0, 16'hCEE5, 0);
    check(rd, tval(tbl[0][0]));
    xfer(0, 1, 16'hD0E5, 16'hCCE5);
    xfer(0, 1, 16'hD0E5, 16'hD4E7);
    xfer(0, 0, 16'hD0E5, 0);
    check(rd, tbl[0][0]);
    xfer(0, 1, 16'hD0E5, 16'hD4E8);
    xfer(0, 0, 16'hD0E5, 0);
    check(rd, 16'hD4E8);
    $display("refusal test done");
    // A float occupies two consecutive slots, loaded by two single-register writes.
    xfer(2, 1, 16'hD0E5, 16'h4000);
    xfer(2, 1, 16'hD0E6, 16'h4001);
    xfer(2, 1, 16'hD2E6, 16'h3F80);
    xfer(2, 0, 16'hD2E5, 0);
    check(rd, tval(16'h4000));
    xfer(2, 0, 16'hD2E6, 0);
    check(rd, 16'h3F80);
    $display("float test done");
    @(posedge clk);
    #1 {host_drop, drop_host} = {1'b1, 2'd1};
    @(posedge clk);
    #1 host_drop = 0;
    xfer(1, 0, 16'hD0E5, 0);
    check(rd, 16'h0000);
    xfer(2, 0, 16'hD0E6, 0);
    check(rd, 16'h4001);
    @(posedge clk);
    #1 power_fail = 1;
    @(posedge clk);
    #1 power_fail = 0;
    repeat (6) @(posedge clk);
    for (int h = 0; h < 4; h++)
    begin
        xfer(h, 0, 16'hCCE8, 0);
        check(rd, 16'h0000);
    end
    $display("clear test done");
    conclude();
end
initial begin
    #200000;
    n_errors++;
    conclude();
end
endmodule
bind modbus_indirection_tables modbus_indirection_tables_props #(.ENTRIES(ENTRIES)) props_inst (.*);

// ---- tgt_model.sv ----
`timescale 1ns/100ps
module tgt_model(
    input wire clk,
    input wire reset_n,
    input wire tgt_valid,
    input wire tgt_write,
    input wire [15:0] tgt_addr,
    input wire [15:0] tgt_wdata,
    input wire [1:0] lag,
    output logic tgt_ready,
    output logic [15:0] tgt_rdata
);
logic [15:0] mem [int];
int cnt;
// Read data is only good with ready; otherwise it toggles, except while the lag count runs, so stale use shows.
always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
        tgt_ready <= 1'b0;
        tgt_rdata <= 16'h0000;
        cnt <= 0;
    end
    else if (tgt_valid && !tgt_ready && cnt < lag)
        cnt <= cnt + 1;
    else if (tgt_valid && !tgt_ready)
    begin
        tgt_ready <= 1'b1;
        cnt <= 0;
        if (tgt_write)
            mem[tgt_addr] = tgt_wdata;
        tgt_rdata <= mem.exists(tgt_addr) ? mem[tgt_addr] : ~tgt_addr;
    end
    else
    begin
        tgt_ready <= 1'b0;
        tgt_rdata <= ~tgt_rdata;
    end
endmodule
